// ### include/synth_mode_pkg.sv
// Package with field layouts, control addresses and state types of the mode decoder.
package synth_mode_pkg;
    // Serial word geometry.
    localparam int WORD_W = 24;
    localparam int ADDR_W = 4;
    localparam int ADDR_LSB = 0;
    localparam int DATA_LSB = 4;
    // Control addresses of the decoded words.
    localparam logic [3:0] MODE_ADDR = 4'hb;
    localparam logic [3:0] EXT_ADDR = 4'hd;
    // The main divider word has 23 data bits, so only its lowest address bit decodes it.
    localparam logic [3:0] MAIN_ADDR_MASK = 4'h1;
    localparam logic [3:0] MAIN_ADDR_VAL = 4'h0;
    // Mode word field positions.
    localparam int MODE_LSB = 4;
    localparam int MODE_MSB = 18;
    localparam int MODE_ZERO_LSB = 19;
    // Extension word field positions.
    localparam int NUM_EXT_LSB = 4;
    localparam int DEN_EXT_LSB = 14;
    localparam int EXT_W = 10;
    localparam int BASE_W = 12;
    localparam int FRAC_W = 22;
    // Test pin select codes.
    localparam logic [3:0] TP_HIZ = 4'h0;
    localparam logic [3:0] TP_HIGH = 4'h1;
    localparam logic [3:0] TP_LOW = 4'h2;
    localparam logic [3:0] TP_DL_BOTH = 4'h3;
    localparam logic [3:0] TP_DL_MAIN = 4'h4;
    localparam logic [3:0] TP_DL_AUX = 4'h5;
    localparam logic [3:0] TP_ALOD_BOTH = 4'h6;
    localparam logic [3:0] TP_ALOD_MAIN = 4'h7;
    localparam logic [3:0] TP_ALOD_AUX = 4'h8;
    localparam logic [3:0] TP_AL_BOTH = 4'h9;
    localparam logic [3:0] TP_AL_MAIN = 4'ha;
    localparam logic [3:0] TP_AL_AUX = 4'hb;
    localparam logic [3:0] TP_AUX_REF = 4'hc;
    localparam logic [3:0] TP_AUX_FB = 4'hd;
    localparam logic [3:0] TP_MAIN_REF = 4'he;
    localparam logic [3:0] TP_MAIN_FB = 4'hf;
    // Auto power-up policies.
    localparam logic [1:0] APU_NONE = 2'h0;
    localparam logic [1:0] APU_MAIN = 2'h1;
    localparam logic [1:0] APU_BOTH = 2'h2;
    // Modulator order codes.
    localparam logic [1:0] ORDER_4TH = 2'h0;
    localparam logic [1:0] ORDER_OFF = 2'h1;
    localparam logic [1:0] ORDER_2ND = 2'h2;
    localparam logic [1:0] ORDER_3RD = 2'h3;
    // Mode word fields, most significant first, laid out as word bits 18 down to 4.
    typedef struct packed {
        logic mainPumpHiz;
        logic mainPumpPolarity;
        logic auxPumpHiz;
        logic auxPumpPolarity;
        logic fractionWidthSelect;
        logic [1:0] modulatorOrder;
        logic [1:0] autoPowerUpSelect;
        logic refDoublerEnable;
        logic refInputDifferential;
        logic [3:0] testPinSelect;
    } mode_cfg_s;
    localparam mode_cfg_s MODE_RESET = '0;
    // Whole state of the decoder.
    typedef struct packed {
        mode_cfg_s mode;
        logic [EXT_W-1:0] denominatorExt;
        logic [EXT_W-1:0] numeratorExt;
        logic [3:0] halfRate;
        logic pinOut;
        logic pinOeN;
        logic mainPowerUp;
        logic auxPowerUp;
        logic mainHizEff;
        logic auxHizEff;
        logic [FRAC_W-1:0] fracNumerator;
        logic [FRAC_W-1:0] fracDenominator;
    } state_s;
endpackage : synth_mode_pkg

// ### logic/synth_mode_config_decode.sv
// Decoder of the synthesizer mode word and fraction extension word into control outputs.
`timescale 1ns/10ps

// How it works
// R1 - Select codes 0-3: hiz, high, low, both digital
// R2 - Codes 4,5: main or auxiliary digital lock
// R3 - Codes 6-8 open-drain analog, 9-11 push-pull analog
// R4 - Codes 12-15: half-rate divider outputs, push-pull
// R5 - Differential bit picks single or paired reference
// R6 - Doubler bit zero bypasses the doubler
// R7 - Power-up policy on main divider word write
// R8 - Pump high-impedance bit: 0 active, 1 hiz
// R9 - Auto power-up overrides pump high-impedance bit
// R10 - Modulator order codes 4th, off, 2nd, 3rd
// R11 - Width bit picks 12-bit or 22-bit fraction
// R12 - Auxiliary polarity: 1 positive, 0 negative
// R13 - Main polarity: 1 positive, 0 negative
// R14 - Data above four-bit control address routes words
// R15 - Wide mode joins extension above base bits
// R16 - Narrow mode ignores extension bits
// R17 - Mode word fields at address 1011
// R18 - Extension fields latched at address 1101
module synth_mode_config_decode
    import synth_mode_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Completed serial words from the shifter.
    input wire logic [WORD_W-1:0] wordIn,
    input wire logic wordLoad,
    // Fraction base bits from the other words.
    input wire logic [BASE_W-1:0] numeratorBase,
    input wire logic [BASE_W-1:0] denominatorBase,
    // Lock indications and divider outputs, all on ref_clk.
    input wire logic mainDigitalLock,
    input wire logic auxDigitalLock,
    input wire logic mainAnalogLock,
    input wire logic auxAnalogLock,
    input wire logic auxRefDivPulse,
    input wire logic auxFbDivPulse,
    input wire logic mainRefDivPulse,
    input wire logic mainFbDivPulse,
    // Test and lock pin.
    output logic testLockOut,
    output logic testLockOe_n,
    // Decoded controls.
    output logic refInputDifferential,
    output logic refDoublerEnable,
    output logic [1:0] modulatorOrder,
    output logic fractionWidthSelect,
    output logic auxPumpPolarity,
    output logic mainPumpPolarity,
    output logic auxPumpHiz,
    output logic mainPumpHiz,
    output logic mainPowerUp,
    output logic auxPowerUp,
    output logic [FRAC_W-1:0] fracNumerator,
    output logic [FRAC_W-1:0] fracDenominator
);
    state_s st_q;
    state_s st_d;
    logic [ADDR_W-1:0] wordAddr;
    logic [3:0] divPulses;

    // Word routing fields.
    assign wordAddr = wordIn[ADDR_LSB +: ADDR_W]; // R14
    assign divPulses = {mainFbDivPulse, mainRefDivPulse, auxFbDivPulse, auxRefDivPulse};

    // Next state: word capture, pin multiplexer, power-up and fraction assembly.
    always_comb begin
        logic mainWrite;
        logic [1:0] apu;
        mainWrite = 1'b0;
        apu = st_q.mode.autoPowerUpSelect;
        st_d = st_q;
        if (wordLoad && wordAddr == MODE_ADDR) begin
            st_d.mode = mode_cfg_s'(wordIn[MODE_MSB:MODE_LSB]); // R17
        end
        if (wordLoad && wordAddr == EXT_ADDR) begin
            st_d.denominatorExt = wordIn[DEN_EXT_LSB +: EXT_W]; // R18
            st_d.numeratorExt = wordIn[NUM_EXT_LSB +: EXT_W]; // R18
        end
        mainWrite = wordLoad && ((wordAddr & MAIN_ADDR_MASK) == MAIN_ADDR_VAL);
        // One-cycle power-up requests follow a main divider word write.
        st_d.mainPowerUp = mainWrite && (apu == APU_MAIN || apu == APU_BOTH); // R7
        st_d.auxPowerUp = mainWrite && apu == APU_BOTH; // R7
        // A power-up policy covering a loop keeps its pump out of high impedance.
        st_d.mainHizEff = st_q.mode.mainPumpHiz && !(apu == APU_MAIN || apu == APU_BOTH); // R8 R9
        st_d.auxHizEff = st_q.mode.auxPumpHiz && apu != APU_BOTH; // R8 R9
        // Half-rate copies of the divider outputs toggle on each pulse.
        for (int i = 0; i < 4; i++) begin
            st_d.halfRate[i] = st_q.halfRate[i] ^ divPulses[i]; // R4
        end
        // Fraction values, extension bits only in wide mode.
        if (st_q.mode.fractionWidthSelect) begin
            st_d.fracNumerator = {st_q.numeratorExt, numeratorBase}; // R15 R11
            st_d.fracDenominator = {st_q.denominatorExt, denominatorBase}; // R15 R11
        end else begin
            st_d.fracNumerator = {{EXT_W{1'b0}}, numeratorBase}; // R16 R11
            st_d.fracDenominator = {{EXT_W{1'b0}}, denominatorBase}; // R16 R11
        end
        // Test pin multiplexer; enable is low while the pin is driven.
        st_d.pinOeN = 1'b0;
        st_d.pinOut = 1'b0;
        unique case (st_q.mode.testPinSelect)
            TP_HIZ: st_d.pinOeN = 1'b1; // R1
            TP_HIGH: st_d.pinOut = 1'b1; // R1
            TP_LOW: st_d.pinOut = 1'b0; // R1
            TP_DL_BOTH: st_d.pinOut = mainDigitalLock & auxDigitalLock; // R1
            TP_DL_MAIN: st_d.pinOut = mainDigitalLock; // R2
            TP_DL_AUX: st_d.pinOut = auxDigitalLock; // R2
            TP_ALOD_BOTH: st_d.pinOeN = mainAnalogLock & auxAnalogLock; // R3
            TP_ALOD_MAIN: st_d.pinOeN = mainAnalogLock; // R3
            TP_ALOD_AUX: st_d.pinOeN = auxAnalogLock; // R3
            TP_AL_BOTH: st_d.pinOut = mainAnalogLock & auxAnalogLock; // R3
            TP_AL_MAIN: st_d.pinOut = mainAnalogLock; // R3
            TP_AL_AUX: st_d.pinOut = auxAnalogLock; // R3
            TP_AUX_REF: st_d.pinOut = st_q.halfRate[0]; // R4
            TP_AUX_FB: st_d.pinOut = st_q.halfRate[1]; // R4
            TP_MAIN_REF: st_d.pinOut = st_q.halfRate[2]; // R4
            TP_MAIN_FB: st_d.pinOut = st_q.halfRate[3]; // R4
        endcase
    end

    // State register with synchronous reset.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_q <= '0;
            st_q.mode <= MODE_RESET;
            st_q.pinOeN <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs taken directly from state flip-flops.
    assign testLockOut = st_q.pinOut;
    assign testLockOe_n = st_q.pinOeN;
    assign refInputDifferential = st_q.mode.refInputDifferential; // R5
    assign refDoublerEnable = st_q.mode.refDoublerEnable; // R6
    assign modulatorOrder = st_q.mode.modulatorOrder; // R10
    assign fractionWidthSelect = st_q.mode.fractionWidthSelect; // R11
    assign auxPumpPolarity = st_q.mode.auxPumpPolarity; // R12
    assign mainPumpPolarity = st_q.mode.mainPumpPolarity; // R13
    assign auxPumpHiz = st_q.auxHizEff;
    assign mainPumpHiz = st_q.mainHizEff;
    assign mainPowerUp = st_q.mainPowerUp;
    assign auxPowerUp = st_q.auxPowerUp;
    assign fracNumerator = st_q.fracNumerator;
    assign fracDenominator = st_q.fracDenominator;

    // Checks of the decoded behaviour.
    property p_tp_hiz;
        @(posedge ref_clk) disable iff (sys_rst)
        st_q.mode.testPinSelect == TP_HIZ |=> testLockOe_n;
    endproperty
    a_tp_hiz: assert property (p_tp_hiz) else $error("Code 0 did not release the pin."); // R1

    property p_tp_dl;
        @(posedge ref_clk) disable iff (sys_rst)
        st_q.mode.testPinSelect == TP_DL_MAIN
            |=> !testLockOe_n && testLockOut == $past(mainDigitalLock);
    endproperty
    a_tp_dl: assert property (p_tp_dl) else $error("Code 4 did not show main lock."); // R2

    property p_tp_od;
        @(posedge ref_clk) disable iff (sys_rst)
        st_q.mode.testPinSelect == TP_ALOD_BOTH
            |=> !testLockOut && testLockOe_n == $past(mainAnalogLock && auxAnalogLock);
    endproperty
    a_tp_od: assert property (p_tp_od) else $error("Code 6 is not open drain lock."); // R3

    property p_half;
        @(posedge ref_clk) disable iff (sys_rst)
        (auxRefDivPulse && st_q.mode.testPinSelect == TP_AUX_REF)
            ##1 (st_q.mode.testPinSelect == TP_AUX_REF)
            |=> testLockOut != $past(testLockOut) && !testLockOe_n;
    endproperty
    a_half: assert property (p_half) else $error("Half-rate output mismatch."); // R4

    property p_mode_load;
        @(posedge ref_clk) disable iff (sys_rst)
        wordLoad && wordIn[3:0] == MODE_ADDR
            |=> modulatorOrder == $past(wordIn[13:12]) && mainPumpPolarity == $past(wordIn[17])
                && refInputDifferential == $past(wordIn[8]);
    endproperty
    a_mode_load: assert property (p_mode_load) else $error("Mode word not captured."); // R17

    property p_pwr;
        @(posedge ref_clk) disable iff (sys_rst)
        wordLoad && wordIn[0] == 1'b0 && st_q.mode.autoPowerUpSelect == APU_BOTH
            |=> mainPowerUp && auxPowerUp;
    endproperty
    a_pwr: assert property (p_pwr) else $error("Power-up pulse wrong."); // R7

    property p_pwr_pulse;
        @(posedge ref_clk) disable iff (sys_rst)
        !(wordLoad && wordIn[0] == 1'b0) |=> !mainPowerUp && !auxPowerUp;
    endproperty
    a_pwr_pulse: assert property (p_pwr_pulse) else $error("Stray power-up pulse."); // R7

    property p_hiz;
        @(posedge ref_clk) disable iff (sys_rst)
        st_q.mode.autoPowerUpSelect == APU_MAIN
            |=> !mainPumpHiz && auxPumpHiz == $past(st_q.mode.auxPumpHiz);
    endproperty
    a_hiz: assert property (p_hiz) else $error("Power-up did not override hiz."); // R9

    property p_hiz_none;
        @(posedge ref_clk) disable iff (sys_rst)
        st_q.mode.autoPowerUpSelect == APU_NONE
            |=> mainPumpHiz == $past(st_q.mode.mainPumpHiz)
                && auxPumpHiz == $past(st_q.mode.auxPumpHiz);
    endproperty
    a_hiz_none: assert property (p_hiz_none) else $error("Pump hiz bit not followed."); // R8

    property p_narrow;
        @(posedge ref_clk) disable iff (sys_rst)
        !fractionWidthSelect |=> fracNumerator[21:12] == 10'h000
            && fracDenominator[11:0] == $past(denominatorBase);
    endproperty
    a_narrow: assert property (p_narrow) else $error("Narrow mode used extension."); // R16

    property p_wide;
        @(posedge ref_clk) disable iff (sys_rst)
        fractionWidthSelect |=> fracDenominator[21:12] == $past(st_q.denominatorExt);
    endproperty
    a_wide: assert property (p_wide) else $error("Wide mode lost extension."); // R15
endmodule : synth_mode_config_decode

// ### testbench/host_word_writer.sv
// Host model that hands complete programming words to the decoder.
`timescale 1ns/10ps
module host_word_writer
    import synth_mode_pkg::*;
(
    // Clock.
    input wire logic ref_clk,
    // Word strobe towards the decoder.
    output logic [WORD_W-1:0] wordIn,
    output logic wordLoad
);
    // The idle bus shows a fresh pattern so a stale word is never reused.
    initial begin
        wordIn = 24'h5a5a5a;
        wordLoad = 1'b0;
    end
    // Sends one word, data above the address, strobed for one cycle.
    task automatic send(input logic [19:0] data, input logic [3:0] addr);
        wordIn = {data, addr};
        wordLoad = 1'b1;
        @(negedge ref_clk);
        wordLoad = 1'b0;
        wordIn = ~{data, addr};
        // One idle cycle so that a following call never rewrites the strobe in the same step.
        @(negedge ref_clk);
    endtask : send
endmodule : host_word_writer

// ### testbench/tb.sv
// Self-checking bench for the mode and fraction extension decoder.
`timescale 1ns/10ps
module tb;
    import synth_mode_pkg::*;
    typedef struct {int due; int id; logic [21:0] e; logic [21:0] m;} note_s;
    // Bench-driven inputs and decoder outputs.
    logic ref_clk, sys_rst, tpOut, tpOe_n, rDiff, rDbl, fWid, aPol, mPol, aHiz, mHiz, mPwr, aPwr;
    logic [11:0] numBase, denBase;
    logic [3:0] lk, pls;
    logic [1:0] mOrd;
    logic [FRAC_W-1:0] fNum, fDen;
    wire [WORD_W-1:0] wordIn;
    wire wordLoad;
    // Bookkeeping.
    int cyc = 0;
    int fails = 0;
    int nChecks = 0;
    int seed;
    int par[4];
    note_s q[$];
    logic [19:0] d, e;
    synth_mode_config_decode dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .wordIn(wordIn),
        .wordLoad(wordLoad), .numeratorBase(numBase), .denominatorBase(denBase),
        .mainDigitalLock(lk[3]), .auxDigitalLock(lk[2]), .mainAnalogLock(lk[1]),
        .auxAnalogLock(lk[0]), .auxRefDivPulse(pls[0]), .auxFbDivPulse(pls[1]),
        .mainRefDivPulse(pls[2]), .mainFbDivPulse(pls[3]), .testLockOut(tpOut),
        .testLockOe_n(tpOe_n), .refInputDifferential(rDiff), .refDoublerEnable(rDbl),
        .modulatorOrder(mOrd), .fractionWidthSelect(fWid), .auxPumpPolarity(aPol),
        .mainPumpPolarity(mPol), .auxPumpHiz(aHiz), .mainPumpHiz(mHiz), .mainPowerUp(mPwr),
        .auxPowerUp(aPwr), .fracNumerator(fNum), .fracDenominator(fDen));
    host_word_writer hostU (.ref_clk(ref_clk), .wordIn(wordIn), .wordLoad(wordLoad));
    // Packs one output group for comparison.
    function automatic logic [21:0] obs(int id);
        case (id)
            0: return {15'h0, mPol, aPol, fWid, mOrd, rDbl, rDiff};
            1: return {20'h0, mHiz, aHiz};
            2: return {20'h0, tpOut, tpOe_n};
            3: return {20'h0, mPwr, aPwr};
            4: return fNum;
            default: return fDen;
        endcase
    endfunction : obs
    // Mode fields of a data word in output order.
    function automatic logic [21:0] mode_exp(logic [19:0] w);
        return {15'h0, w[13], w[11], w[10], w[9:8], w[5], w[4]};
    endfunction : mode_exp
    // Pin data and enable for a select code; l is main and aux digital, then analog.
    function automatic logic [21:0] pin_exp(logic [3:0] c, logic [3:0] l);
        case (c)
            0: return 22'h1;
            1: return 22'h2;
            2: return 22'h0;
            3: return {20'h0, l[3] & l[2], 1'b0};
            4: return {20'h0, l[3], 1'b0};
            5: return {20'h0, l[2], 1'b0};
            6: return {20'h0, 1'b0, l[1] & l[0]};
            7: return {20'h0, 1'b0, l[1]};
            8: return {20'h0, 1'b0, l[0]};
            9: return {20'h0, l[1] & l[0], 1'b0};
            10: return {20'h0, l[1], 1'b0};
            11: return {20'h0, l[0], 1'b0};
            default: return {20'h0, par[c - 12][0], 1'b0};
        endcase
    endfunction : pin_exp
    task automatic note(int due, int id, logic [21:0] ex, logic [21:0] m);
        q.push_back('{due, id, ex, m});
    endtask : note
    // Sends a mode word with fresh lock inputs and notes what it must produce.
    task automatic send_mode(logic [19:0] w);
        logic [1:0] a;
        a = w[7:6];
        lk = 4'($random(seed));
        note(cyc + 1, 0, mode_exp(w), 22'h7f);
        note(cyc + 2, 1, {20'h0, w[14] & !(a == 1 || a == 2), w[12] & (a != 2)}, 22'h3);
        note(cyc + 2, 2, pin_exp(w[3:0], lk), (w[3:0] == 0) ? 22'h1 : 22'h3);
        hostU.send(w, MODE_ADDR);
    endtask : send_mode
    task automatic report_and_stop();
        if (fails == 0 && nChecks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // Cycle count with a ceiling that cuts a hung run short.
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            report_and_stop();
        end
    end
    // Takes the oldest note when its cycle comes and compares it with the outputs.
    always @(negedge ref_clk) begin
        while (q.size() > 0 && q[0].due <= cyc) begin
            nChecks++;
            if (q[0].due != cyc || ((obs(q[0].id) ^ q[0].e) & q[0].m) !== 22'h0) begin
                fails++;
                $display("unexpected at %0t: output group %0d", $time, q[0].id);
            end
            void'(q.pop_front());
        end
    end
    // Main sequence.
    initial begin
        seed = 32'h5f5e;
        sys_rst = 1'b1;
        lk = 4'h0;
        pls = 4'h0;
        numBase = 12'h0;
        denBase = 12'h0;
        par = '{0, 0, 0, 0};
        repeat (8) @(negedge ref_clk);
        sys_rst = 1'b0;
        note(cyc + 1, 0, 22'h0, 22'h7f);
        note(cyc + 1, 2, 22'h1, 22'h3);
        @(negedge ref_clk);
        // Every select code twice, random fields, a half-rate toggle after codes 12 to 15.
        for (int k = 0; k < 32; k++) begin
            d = 20'($random(seed));
            d[3:0] = k[3:0];
            send_mode(d);
            if (k[3:2] == 2'b11) begin
                pls[k[1:0]] = 1'b1;
                par[k[1:0]] ^= 1;
                note(cyc + 2, 2, {20'h0, par[k[1:0]][0], 1'b0}, 22'h3);
                @(negedge ref_clk);
                pls = 4'h0;
            end
        end
        // Each power-up policy against set pump bits, then a main divider word at once.
        for (int a = 0; a < 4; a++) begin
            d = 20'($random(seed));
            d[14] = 1'b1;
            d[12] = 1'b1;
            d[7:6] = a[1:0];
            send_mode(d);
            note(cyc + 1, 3, {20'h0, a == 1 || a == 2, a == 2}, 22'h3);
            note(cyc + 2, 3, 22'h0, 22'h3);
            hostU.send(20'($random(seed)), {3'($random(seed)), 1'b0});
        end
        // Other odd addresses leave the mode fields alone.
        for (int a = 1; a < 16; a += 2) begin
            if (a != 11 && a != 13) hostU.send(20'($random(seed)), a[3:0]);
        end
        note(cyc + 1, 0, mode_exp(d), 22'h7f);
        @(negedge ref_clk);
        // Extension words in narrow then wide mode, all-ones values second in each.
        for (int k = 0; k < 8; k++) begin
            if (k % 4 == 0) begin
                d = 20'($random(seed));
                d[10] = k[2];
                send_mode(d);
            end
            e = (k % 4 == 1) ? 20'hfffff : 20'($random(seed));
            {numBase, denBase} = (k % 4 == 1) ? 24'hffffff : 24'($random(seed));
            note(cyc + 2, 4, {k[2] ? e[9:0] : 10'h0, numBase}, '1);
            note(cyc + 2, 5, {k[2] ? e[19:10] : 10'h0, denBase}, '1);
            hostU.send(e, EXT_ADDR);
            @(negedge ref_clk);
        end
        // Reset in mid-run clears every output and releases the pin; mode outputs and pin are checked again one edge after.
        sys_rst = 1'b1;
        for (int i = 0; i < 6; i++) begin
            note(cyc + 1, i, (i == 2) ? 22'h1 : 22'h0, '1);
        end
        @(negedge ref_clk);
        sys_rst = 1'b0;
        note(cyc + 1, 0, 22'h0, 22'h7f);
        note(cyc + 1, 2, 22'h1, 22'h3);
        @(negedge ref_clk);
        repeat (4) @(negedge ref_clk);
        fails += q.size();
        report_and_stop();
    end
endmodule : tb
